// File: bus_status_map.svh
// Constants for the bus status signalling block
`ifndef BUS_STATUS_MAP_SVH
`define BUS_STATUS_MAP_SVH
`define QS_NONE        2'h0
`define QS_FIRST       2'h1
`define QS_FLUSH       2'h2
`define QS_NEXT        2'h3
`define NMI_VECTOR     8'h02
`define MID_SEL_COUNT  4
`define PERIPH_COUNT   7
`define PERIPH_ADDR1   5
`define PERIPH_ADDR2   6
`define PERIPH_IDLE    7'h7F
`endif

// File: bus_status_pkg.sv
// Types for the bus status signalling block
package bus_status_pkg;
    typedef enum logic [1:0] {
        BUS_OWNED    = 2'h0,
        BUS_RELEASED = 2'h1
    } bus_state_e;
    typedef logic [1:0] queue_op_t;
endpackage

// File: sync_bit.sv
// Two-flop synchroniser for one bit
`timescale 1ns/1ps
module sync_bit (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic stage1Reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1Reg <= 1'b0;
            dout      <= 1'b0;
        end else begin
            stage1Reg <= din;
            dout      <= stage1Reg;
        end
    end
endmodule // sync_bit

// File: cpu_bus_status_signalling.sv
// Bus lock, hold arbitration, NMI, queue status and chip select outputs
//
// Summary of operation
// RL1: Drive lockN low while the current bus cycle must not be interrupted.
// RL2: Never grant hold while lock output is asserted.
// RL3: During reset the lock pin is weakly pulled high; nobody drives it low.
// RL4: A rising nmi input raises a type 2 non-maskable interrupt request.
// RL5: Queue status codes: 00 none, 01 first byte, 11 next byte, 10 flush.
// RL6: Queue mode strap on the read pin is sampled only during reset.
// RL7: Read strobe is asserted low during read cycles; device drives data.
// RL8: Provide active-low mid-range memory selects, some shared with other functions.
// RL9: Seven active-low peripheral selects; 5 and 6 may present latched A1, A2.
// RL10: Bus released only at instruction boundaries, never inside locked instruction.
// RL11: Strap held low during reset enters queue status mode.
// RL12: In queue status mode the status bits replace ALE and write strobe.
`include "bus_status_map.svh"
`timescale 1ns/1ps
module cpu_bus_status_signalling
    import bus_status_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic                      lockCycle,
    input  wire logic                      instrBoundary,
    input  wire logic                      holdRequest,
    input  wire logic                      nmiPin,
    input  wire logic                      nmiTaken,
    input  wire bus_status_pkg::queue_op_t queueOp,
    input  wire logic                      readCycle,
    input  wire logic                      writeStrobe,
    input  wire logic                      addrLatch,
    input  wire logic                      qsModeStrapPin,
    input  wire logic [3:0]                midSelHit,
    input  wire logic [6:0]                periphHit,
    input  wire logic                      periphAddrMode,
    input  wire logic [2:1]                busAddr,
    output logic                           lockN,
    output logic                           lockOe,
    output logic                           lockPullup,
    output logic                           holdAck,
    output logic                           nmiRequest,
    output logic [7:0]                     nmiVector,
    output logic                           queueStateMode,
    output logic                           queue_state_bit0,
    output logic                           queue_state_bit1,
    output logic                           readN,
    output logic                           readOe,
    output logic                           midrange_mem_select0,
    output logic                           midrange_mem_select1,
    output logic                           midrange_mem_select2,
    output logic                           midrange_mem_select3,
    output logic [6:0]                     periphSelN
);
    import bus_status_pkg::*;

    logic       nmiSync;
    logic       holdSync;
    logic       strapSync;
    logic       nmiPrevReg;
    bus_state_e busStateReg;
    logic [6:0] periphNext;
    logic [1:0] qsNext;

    sync_bit uNmiSync (.ref_clk(ref_clk), .rst(rst), .din(nmiPin), .dout(nmiSync));
    sync_bit uHoldSync (.ref_clk(ref_clk), .rst(rst), .din(holdRequest), .dout(holdSync));
    sync_bit uStrapSync (.ref_clk(ref_clk), .rst(1'b0), .din(qsModeStrapPin), .dout(strapSync));

    // Lock output and weak pull during reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lockN      <= 1'b1;
            lockOe     <= 1'b0; // [RL3]
            lockPullup <= 1'b1; // [RL3]
        end else begin
            lockN      <= ~lockCycle; // [RL1]
            lockOe     <= 1'b1;
            lockPullup <= 1'b0;
        end
    end

    // Hold arbitration
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busStateReg <= BUS_OWNED;
            holdAck     <= 1'b0;
        end else begin
            unique case (busStateReg)
                BUS_OWNED: begin
                    if (holdSync && instrBoundary && !lockCycle && lockN) begin // [RL2] [RL10]
                        busStateReg <= BUS_RELEASED;
                        holdAck     <= 1'b1;
                    end
                end
                BUS_RELEASED: begin
                    if (!holdSync) begin
                        busStateReg <= BUS_OWNED;
                        holdAck     <= 1'b0;
                    end
                end
            endcase
        end
    end

    // NMI edge capture; a new edge wins over a same-cycle acknowledge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nmiPrevReg <= 1'b0;
            nmiRequest <= 1'b0;
            nmiVector  <= `NMI_VECTOR;
        end else begin
            nmiPrevReg <= nmiSync;
            nmiVector  <= `NMI_VECTOR; // [RL4]
            if (nmiSync && !nmiPrevReg) begin
                nmiRequest <= 1'b1; // [RL4]
            end else if (nmiTaken) begin
                nmiRequest <= 1'b0;
            end
        end
    end

    // Strap sampled only while reset is held
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            queueStateMode <= ~strapSync; // [RL6] [RL11]
        end
    end

    always_comb begin
        unique case (queueOp)
            `QS_NONE:  qsNext = `QS_NONE;
            `QS_FIRST: qsNext = `QS_FIRST;
            `QS_NEXT:  qsNext = `QS_NEXT;
            `QS_FLUSH: qsNext = `QS_FLUSH;
        endcase
    end

    // Shared pins: queue status or ALE / write strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            queue_state_bit0 <= 1'b0;
            queue_state_bit1 <= 1'b1;
        end else if (queueStateMode) begin
            queue_state_bit0 <= qsNext[0]; // [RL5] [RL12]
            queue_state_bit1 <= qsNext[1]; // [RL5] [RL12]
        end else begin
            queue_state_bit0 <= addrLatch;
            queue_state_bit1 <= ~writeStrobe;
        end
    end

    // Read strobe; released during every reset so strap can be read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            readN  <= 1'b1;
            readOe <= 1'b0;
        end else begin
            readN  <= ~readCycle; // [RL7]
            readOe <= 1'b1;
        end
    end

    // Mid-range memory selects
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            midrange_mem_select0 <= 1'b1;
            midrange_mem_select1 <= 1'b1;
            midrange_mem_select2 <= 1'b1;
            midrange_mem_select3 <= 1'b1;
        end else begin
            midrange_mem_select0 <= ~midSelHit[0]; // [RL8]
            midrange_mem_select1 <= ~midSelHit[1]; // [RL8]
            midrange_mem_select2 <= ~midSelHit[2]; // [RL8]
            midrange_mem_select3 <= ~midSelHit[3]; // [RL8]
        end
    end

    // Peripheral selects, upper two optionally address bits
    genvar gi;
    generate
        for (gi = 0; gi < `PERIPH_COUNT; gi++) begin : gPeriph
            if (gi == `PERIPH_ADDR1) begin : gA1
                assign periphNext[gi] = periphAddrMode ? busAddr[1] : ~periphHit[gi]; // [RL9]
            end else if (gi == `PERIPH_ADDR2) begin : gA2
                assign periphNext[gi] = periphAddrMode ? busAddr[2] : ~periphHit[gi]; // [RL9]
            end else begin : gSel
                assign periphNext[gi] = ~periphHit[gi]; // [RL9]
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            periphSelN <= `PERIPH_IDLE;
        end else begin
            periphSelN <= periphNext;
        end
    end

    AST_LOCK_FOLLOWS: assert property (@(posedge ref_clk) disable iff (rst)
        lockCycle |=> !lockN) else $error("lock not asserted"); // [RL1]
    AST_NO_GRANT_LOCKED: assert property (@(posedge ref_clk) disable iff (rst)
        (!lockN && !holdAck) |=> !holdAck) else $error("hold granted while locked"); // [RL2]
    AST_RESET_PULL: assert property (@(posedge ref_clk)
        rst |=> (lockPullup && !lockOe)) else $error("lock pin not released in reset"); // [RL3]
    AST_NMI_EDGE: assert property (@(posedge ref_clk) disable iff (rst)
        (nmiSync && !nmiPrevReg) |=> (nmiRequest && nmiVector == `NMI_VECTOR)) else $error("nmi lost"); // [RL4]
    AST_QS_CODE: assert property (@(posedge ref_clk) disable iff (rst)
        (queueStateMode && queueOp == `QS_FIRST) |=> (queue_state_bit1 == 1'b0 && queue_state_bit0))
        else $error("queue code wrong"); // [RL5]
    AST_STRAP_HELD: assert property (@(posedge ref_clk) disable iff (rst)
        !rst |=> $stable(queueStateMode)) else $error("strap resampled"); // [RL6]
    AST_READ: assert property (@(posedge ref_clk) disable iff (rst)
        readCycle |=> !readN) else $error("read strobe missing"); // [RL7]
    AST_GRANT_BOUNDARY: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(holdAck) |-> $past(instrBoundary) && !$past(lockCycle)) else $error("bad release"); // [RL10]
    AST_PCS_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
        periphAddrMode |=> periphSelN[5] == $past(busAddr[1])) else $error("a1 not shown"); // [RL9]
endmodule // cpu_bus_status_signalling

// File: far_side_model.sv
// Far-side model: external bus master and reset-time strap driver
`timescale 1ns/1ps
module far_side_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic wantBus,
    input  wire logic strapLow,
    output logic      holdRequest,
    output logic      qsModeStrapPin
);
    // Strap driven low only while reset is applied, pull-up level otherwise
    assign qsModeStrapPin = (rst && strapLow) ? 1'b0 : 1'b1;
    // Bus request pin; no driver on the lock pin at any time
    assign holdRequest = wantBus;
endmodule // far_side_model

// File: test_cpu_bus_status_signalling.sv
// Self-checking testbench for the bus status signalling block
`timescale 1ns/1ps
module test_cpu_bus_status_signalling;
    import bus_status_pkg::*;
    logic ref_clk, rst, lockCycle, instrBoundary, holdRequest, nmiPin, nmiTaken, readCycle;
    logic writeStrobe, addrLatch, qsModeStrapPin, periphAddrMode, wantBus, strapLow;
    logic lockN, lockOe, lockPullup, holdAck, nmiRequest, queueStateMode, readN, readOe;
    logic queue_state_bit0, queue_state_bit1;
    logic midrange_mem_select0, midrange_mem_select1, midrange_mem_select2, midrange_mem_select3;
    queue_op_t  queueOp;
    logic [3:0] midSelHit;
    logic [6:0] periphHit, periphSelN;
    logic [2:1] busAddr;
    logic [7:0] nmiVector;
    int         mismatches = 0;
    int         nChecks = 0;

    cpu_bus_status_signalling dut (
        .ref_clk              (ref_clk),
        .rst                  (rst),
        .lockCycle            (lockCycle),
        .instrBoundary        (instrBoundary),
        .holdRequest          (holdRequest),
        .nmiPin               (nmiPin),
        .nmiTaken             (nmiTaken),
        .queueOp              (queueOp),
        .readCycle            (readCycle),
        .writeStrobe          (writeStrobe),
        .addrLatch            (addrLatch),
        .qsModeStrapPin       (qsModeStrapPin),
        .midSelHit            (midSelHit),
        .periphHit            (periphHit),
        .periphAddrMode       (periphAddrMode),
        .busAddr              (busAddr),
        .lockN                (lockN),
        .lockOe               (lockOe),
        .lockPullup           (lockPullup),
        .holdAck              (holdAck),
        .nmiRequest           (nmiRequest),
        .nmiVector            (nmiVector),
        .queueStateMode       (queueStateMode),
        .queue_state_bit0     (queue_state_bit0),
        .queue_state_bit1     (queue_state_bit1),
        .readN                (readN),
        .readOe               (readOe),
        .midrange_mem_select0 (midrange_mem_select0),
        .midrange_mem_select1 (midrange_mem_select1),
        .midrange_mem_select2 (midrange_mem_select2),
        .midrange_mem_select3 (midrange_mem_select3),
        .periphSelN           (periphSelN)
    );
    far_side_model partner (.ref_clk(ref_clk), .rst(rst), .wantBus(wantBus), .strapLow(strapLow),
                            .holdRequest(holdRequest), .qsModeStrapPin(qsModeStrapPin));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        if (mismatches == 0 && nChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_high(input bit nmi);
        for (int i = 0; i < 10; i++) begin
            if ((nmi ? nmiRequest : holdAck) === 1'b1) return;
            step();
        end
        mismatches++;
        $display("unexpected at %0t: wait timed out", $time);
        finish_test();
    endtask

    task automatic t_reset(input logic strap);
        strapLow = strap;
        rst = 1'b1;
        step(5);
        chk(8'({lockN, lockOe, lockPullup}), 8'h05);
        rst = 1'b0;
        step();
        chk(8'(queueStateMode), 8'(strap));
        chk(8'({lockN, lockOe, lockPullup, readOe}), 8'h0D);
    endtask

    task automatic t_read_lock_hold();
        readCycle = 1'b1;
        step();
        chk(8'(readN), 8'h00);
        {readCycle, lockCycle, instrBoundary, wantBus} = 4'hF;
        step();
        chk(8'({readN, lockN}), 8'h00);
        step(6);
        chk(8'(holdAck), 8'h00);
        {lockCycle, instrBoundary} = 2'h0;
        step(6);
        chk(8'({lockN, holdAck}), 8'h02);
        instrBoundary = 1'b1;
        wait_high(1'b0);
        wantBus = 1'b0;
        step(6);
        chk(8'(holdAck), 8'h00);
    endtask

    task automatic t_nmi();
        nmiPin = 1'b1;
        wait_high(1'b1);
        chk(nmiVector, 8'h02);
        {nmiPin, nmiTaken} = 2'h1;
        step();
        nmiTaken = 1'b0;
        step();
        chk(8'(nmiRequest), 8'h00);
    endtask

    task automatic t_queue_sel();
        for (int c = 0; c < 4; c++) begin
            queueOp = queue_op_t'(c);
            step();
            chk(8'({queue_state_bit1, queue_state_bit0}), 8'(c));
        end
        chk(8'(queueStateMode), 8'h01);
        for (int i = 0; i < 4; i++) begin
            midSelHit = 4'h1 << i;
            step();
            chk(8'({midrange_mem_select3, midrange_mem_select2, midrange_mem_select1,
                    midrange_mem_select0}), 8'({~(4'h1 << i)}));
        end
        for (int i = 0; i < 7; i++) begin
            periphHit = 7'h01 << i;
            step();
            chk(8'(periphSelN), 8'({~(7'h01 << i)}));
        end
        {periphHit, periphAddrMode, busAddr} = {7'h00, 1'b1, 2'h2};
        step();
        chk(8'(periphSelN[6:5]), 8'h02);
    endtask

    task automatic t_shared_pins();
        {addrLatch, writeStrobe} = 2'h3;
        step();
        chk(8'({queue_state_bit1, queue_state_bit0}), 8'h01);
        {addrLatch, writeStrobe} = 2'h0;
        step();
        chk(8'({queue_state_bit1, queue_state_bit0}), 8'h02);
    endtask

    initial begin
        {lockCycle, instrBoundary, nmiPin, nmiTaken, readCycle, writeStrobe, addrLatch} = 7'h00;
        {periphAddrMode, wantBus, queueOp, midSelHit, periphHit, busAddr} = '0;
        rst = 1'b1;
        strapLow = 1'b1;
        t_reset(1'b1);
        t_read_lock_hold();
        t_nmi();
        t_queue_sel();
        t_reset(1'b0);
        t_shared_pins();
        finish_test();
    end
endmodule // test_cpu_bus_status_signalling
